/* shared/tpm_pkg.sv */
// constants, types and helper functions of the transducer period meter
//----------------------------------------------------------------------
// Summary of operation
//----------------------------------------------------------------------
// Summary of operation
// - timer advances once per machine cycle of twelve clocks
// - every falling input edge raises an event when edge events are on
// - period mode: count N falls, then reload, capture, preset, restart
// - after a period capture the timer takes the compensation value, not zero
// - pulse count N is a software value, never zero
// - result is table entry at captured count minus minimum count
// - gate mode: timer counts only while the input is high
// - gated counting needs no processor action and runs during idle
// - in gate mode the halting fall also raises an event
// - gated width depends on the input level only, not on latency
package tpm_pkg;

   //----------------------------------------------------------------------
   // timing
   //----------------------------------------------------------------------
   localparam int MC_CLKS = 12;  // oscillator clocks per machine cycle
   localparam logic [3:0] MC_LAST = 4'(MC_CLKS - 1);

   //----------------------------------------------------------------------
   // register byte offsets
   //----------------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PULSES = 8'h04;
   localparam logic [7:0] OFS_PRESET = 8'h08;
   localparam logic [7:0] OFS_MIN = 8'h0C;
   localparam logic [7:0] OFS_TIMER = 8'h10;
   localparam logic [7:0] OFS_ELAPSED = 8'h14;
   localparam logic [7:0] OFS_RESULT = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1C;
   localparam logic [7:0] OFS_MASK = 8'h20;
   localparam logic [7:0] OFS_TBL_IDX = 8'h24;
   localparam logic [7:0] OFS_TBL_DATA = 8'h28;

   //----------------------------------------------------------------------
   // reset values and sizes
   //----------------------------------------------------------------------
   localparam logic [7:0] PULSES_RST = 8'h09;
   localparam logic [15:0] PRESET_RST = 16'h0009;
   localparam logic [15:0] MIN_RST = 16'h03E7;
   localparam int TBL_DEPTH = 270;
   localparam int TBL_IW = 9;

   //----------------------------------------------------------------------
   // status and mask bit positions
   //----------------------------------------------------------------------
   localparam int ST_EDGE = 0;
   localparam int ST_CAPT = 1;
   localparam int ST_GATE = 2;
   localparam int ST_RANGE = 3;
   localparam int ST_W = 4;

   // control register layout, bit 2 downward
   typedef struct packed {
      logic edge_irq_en;
      logic gate_mode;
      logic timer_run_control;
   } tpm_ctrl_s;

   // conversion sequencer
   typedef enum logic [0:0] {
      CV_IDLE,
      CV_LOOK
   } tpm_conv_e;

   // byte-lane merge of a bus write into a register
   function automatic logic [31:0] tpm_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // table offset of a count, bit 16 set when the count is below the minimum
   function automatic logic [16:0] tpm_tbl_off(input logic [15:0] cnt,
                                               input logic [15:0] min_v);
      return {1'b0, cnt} - {1'b0, min_v};
   endfunction

endpackage

/* verilog/tpm_edge_sync.sv */
// input synchroniser and machine-cycle falling edge detector
`timescale 1ns/10ps
module tpm_edge_sync (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // pin and machine cycle strobe
   input wire logic pin_i,
   input wire logic tick_i,
   // sampled level and fall pulse
   output logic level_o,
   output logic fall_o
);
   logic meta_q;
   logic sync_q;
   logic smp_q;

   // two flops against metastability, then one sample per machine cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         smp_q <= 1'b0;
      end else begin
         meta_q <= pin_i;
         sync_q <= meta_q;
         if (tick_i) begin
            smp_q <= sync_q;
         end
      end
   end

   // fall seen between two consecutive machine cycle samples
   assign level_o = smp_q;
   assign fall_o = tick_i & smp_q & ~sync_q;

   a_fall_on_tick: assert property (@(posedge clk_i) disable iff (rst_i)
      fall_o |=> !level_o && !fall_o) else $error("fall not followed by low");

endmodule // tpm_edge_sync

/* verilog/tpm_lut.sv */
// flip-flop lookup table with one write port and two read ports
`timescale 1ns/10ps
module tpm_lut #(
   parameter int DEPTH = tpm_pkg::TBL_DEPTH,
   parameter int IW = tpm_pkg::TBL_IW,
   parameter int DW = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // write port
   input wire logic wr_en_i,
   input wire logic [IW-1:0] wr_idx_i,
   input wire logic [DW-1:0] wr_data_i,
   // read ports
   input wire logic [IW-1:0] rd_a_idx_i,
   output logic [DW-1:0] rd_a_data_o,
   input wire logic [IW-1:0] rd_b_idx_i,
   output logic [DW-1:0] rd_b_data_o
);
   logic [DW-1:0] mem_q [DEPTH];

   // entries clear at reset, writes beyond the depth are dropped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
      end else if (wr_en_i && (32'(wr_idx_i) < DEPTH)) begin
         mem_q[wr_idx_i] <= wr_data_i;
      end
   end

   // reads beyond the depth return zero
   assign rd_a_data_o = (32'(rd_a_idx_i) < DEPTH) ? mem_q[rd_a_idx_i] : '0;
   assign rd_b_data_o = (32'(rd_b_idx_i) < DEPTH) ? mem_q[rd_b_idx_i] : '0;

endmodule // tpm_lut

/* verilog/tpm_top.sv */
// transducer period meter: timer, capture, lookup, interrupts, bus slave
//
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
module tpm_top #(
   parameter int AW = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [AW-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // transducer pulse input
   input wire logic xdcr_pin_i,
   // interrupt toward the processor
   output logic irq_o
);
   //----------------------------------------------------------------------
   // declarations
   //----------------------------------------------------------------------
   tpm_pkg::tpm_ctrl_s ctrl_q;
   tpm_pkg::tpm_conv_e conv_q;
   logic [3:0] mc_cnt_q;
   logic mc_tick;
   logic level;
   logic fall;
   logic [15:0] timer_q;
   logic [7:0] pulses_q;
   logic [7:0] pulse_cnt_q;
   logic [15:0] preset_q;
   logic [15:0] min_q;
   logic [15:0] elapsed_q;
   logic [7:0] result_q;
   logic [tpm_pkg::ST_W-1:0] status_q;
   logic [tpm_pkg::ST_W-1:0] mask_q;
   logic [tpm_pkg::ST_W-1:0] st_set;
   logic [tpm_pkg::TBL_IW-1:0] tbl_idx_q;
   logic [7:0] lut_conv;
   logic [7:0] lut_bus;
   logic [16:0] conv_off;
   logic conv_ok;
   logic period_done;
   logic gate_done;
   logic bus_req;
   logic bus_wr;
   logic bus_rd;
   logic [7:0] adr;
   logic [31:0] rd_d;

   //----------------------------------------------------------------------
   // machine cycle prescaler
   //----------------------------------------------------------------------
   // one tick every twelve oscillator clocks, free running
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mc_cnt_q <= '0;
      end else if (mc_cnt_q == tpm_pkg::MC_LAST) begin
         mc_cnt_q <= '0;
      end else begin
         mc_cnt_q <= mc_cnt_q + 4'h1;
      end
   end

   assign mc_tick = (mc_cnt_q == tpm_pkg::MC_LAST);

   a_mc_tick_period: assert property (@(posedge clk_i) disable iff (rst_i)
      mc_tick |-> ##12 mc_tick) else $error("machine cycle not twelve clocks");

   a_mc_tick_gap: assert property (@(posedge clk_i) disable iff (rst_i)
      mc_tick |=> !mc_tick [*8]) else $error("machine cycle tick too soon");

   //----------------------------------------------------------------------
   // input synchroniser and edge detector
   //----------------------------------------------------------------------
   tpm_edge_sync u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(xdcr_pin_i),
      .tick_i(mc_tick),
      .level_o(level),
      .fall_o(fall)
   );

   //----------------------------------------------------------------------
   // bus decode
   //----------------------------------------------------------------------
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_wr = bus_req & wb_we_i;
   assign bus_rd = bus_req & ~wb_we_i;
   assign adr = {wb_adr_i[7:2], 2'b00};

   //----------------------------------------------------------------------
   // measurement events
   //----------------------------------------------------------------------
   // period mode completes on the fall that empties the pulse counter
   assign period_done = fall & ctrl_q.timer_run_control & ~ctrl_q.gate_mode
                        & (pulse_cnt_q == 8'h01);
   // gate mode completes on each fall that closes the gate
   assign gate_done = fall & ctrl_q.timer_run_control & ctrl_q.gate_mode;

   //----------------------------------------------------------------------
   // control and configuration registers
   //----------------------------------------------------------------------
   // software steers mode, run and edge events; zero pulse counts forced to one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= '0;
         pulses_q <= tpm_pkg::PULSES_RST;
         preset_q <= tpm_pkg::PRESET_RST;
         min_q <= tpm_pkg::MIN_RST;
         mask_q <= '0;
      end else if (bus_wr) begin
         case (adr)
            tpm_pkg::OFS_CTRL: begin
               ctrl_q <= 3'(tpm_pkg::tpm_merge(32'(ctrl_q), wb_dat_i, wb_sel_i));
            end
            tpm_pkg::OFS_PULSES: begin
               if (wb_sel_i[0]) begin
                  pulses_q <= (wb_dat_i[7:0] == 8'h00) ? 8'h01 : wb_dat_i[7:0];
               end
            end
            tpm_pkg::OFS_PRESET: begin
               preset_q <= 16'(tpm_pkg::tpm_merge(32'(preset_q), wb_dat_i, wb_sel_i));
            end
            tpm_pkg::OFS_MIN: begin
               min_q <= 16'(tpm_pkg::tpm_merge(32'(min_q), wb_dat_i, wb_sel_i));
            end
            tpm_pkg::OFS_MASK: begin
               mask_q <= tpm_pkg::ST_W'(tpm_pkg::tpm_merge(32'(mask_q), wb_dat_i,
                                                           wb_sel_i));
            end
            default: begin
            end
         endcase
      end
   end

   //----------------------------------------------------------------------
   // pulse counter
   //----------------------------------------------------------------------
   // counts falls down to one, reloads with N on the next fall; reloads when idle or gated
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pulse_cnt_q <= tpm_pkg::PULSES_RST;
      end else if (!ctrl_q.timer_run_control || ctrl_q.gate_mode) begin
         pulse_cnt_q <= pulses_q;
      end else if (period_done) begin
         pulse_cnt_q <= pulses_q;
      end else if (fall) begin
         pulse_cnt_q <= pulse_cnt_q - 8'h01;
      end
   end

   a_pulse_nonzero: assert property (@(posedge clk_i) disable iff (rst_i)
      pulse_cnt_q != 8'h00) else $error("pulse counter reached zero");

   a_period_reload: assert property (@(posedge clk_i) disable iff (rst_i)
      period_done |=> pulse_cnt_q == $past(pulses_q)) else $error("pulse count not reloaded");

   //----------------------------------------------------------------------
   // measurement timer
   //----------------------------------------------------------------------
   // measurement events beat software writes; gate holds count while low
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_q <= '0;
      end else if (period_done) begin
         timer_q <= preset_q;
      end else if (gate_done) begin
         timer_q <= '0;
      end else if (bus_wr && adr == tpm_pkg::OFS_TIMER) begin
         timer_q <= 16'(tpm_pkg::tpm_merge(32'(timer_q), wb_dat_i, wb_sel_i));
      end else if (mc_tick && ctrl_q.timer_run_control
                   && (!ctrl_q.gate_mode || level)) begin
         // no processor gating here: counting continues through idle
         timer_q <= timer_q + 16'h0001;
      end
   end

   a_preset_load: assert property (@(posedge clk_i) disable iff (rst_i)
      period_done |=> timer_q == $past(preset_q)) else $error("timer not preset");

   a_gate_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_q.gate_mode && !level && !fall && !bus_wr |=> $stable(timer_q))
      else $error("gated timer moved while input low");

   a_gate_count: assert property (@(posedge clk_i) disable iff (rst_i)
      ctrl_q.gate_mode && ctrl_q.timer_run_control && level && mc_tick && !bus_wr && !fall
      |=> timer_q == $past(timer_q) + 16'h0001)
      else $error("gated timer stalled while input high");

   //----------------------------------------------------------------------
   // capture register
   //----------------------------------------------------------------------
   // caught by the input edge itself, counting the capture tick so no cycle is lost
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         elapsed_q <= '0;
      end else if (period_done || gate_done) begin
         elapsed_q <= timer_q + 16'h0001;
      end
   end

   a_capture_value: assert property (@(posedge clk_i) disable iff (rst_i)
      period_done || gate_done |=> elapsed_q == $past(timer_q) + 16'h0001)
      else $error("capture lost the timer value");

   //----------------------------------------------------------------------
   // table conversion
   //----------------------------------------------------------------------
   assign conv_off = tpm_pkg::tpm_tbl_off(elapsed_q, min_q);
   assign conv_ok = ~conv_off[16] && (conv_off[15:0] < 16'(tpm_pkg::TBL_DEPTH));

   tpm_lut u_lut (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_en_i(bus_wr && adr == tpm_pkg::OFS_TBL_DATA && wb_sel_i[0]),
      .wr_idx_i(tbl_idx_q),
      .wr_data_i(wb_dat_i[7:0]),
      .rd_a_idx_i(conv_off[tpm_pkg::TBL_IW-1:0]),
      .rd_a_data_o(lut_conv),
      .rd_b_idx_i(tbl_idx_q),
      .rd_b_data_o(lut_bus)
   );

   // one cycle after capture the result takes the table entry when the offset is in range
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         conv_q <= tpm_pkg::CV_IDLE;
         result_q <= '0;
      end else begin
         case (conv_q)
            tpm_pkg::CV_IDLE: begin
               if (period_done || gate_done) begin
                  conv_q <= tpm_pkg::CV_LOOK;
               end
            end
            tpm_pkg::CV_LOOK: begin
               if (conv_ok) begin
                  result_q <= lut_conv;
               end
               conv_q <= tpm_pkg::CV_IDLE;
            end
            default: begin
               conv_q <= tpm_pkg::CV_IDLE;
            end
         endcase
      end
   end

   a_lookup_result: assert property (@(posedge clk_i) disable iff (rst_i)
      conv_q == tpm_pkg::CV_LOOK && conv_ok |=> result_q == $past(lut_conv))
      else $error("result not taken from table");

   // table index register, advanced by each data write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tbl_idx_q <= '0;
      end else if (bus_wr && adr == tpm_pkg::OFS_TBL_IDX && wb_sel_i[0]) begin
         tbl_idx_q <= tpm_pkg::TBL_IW'(tpm_pkg::tpm_merge(32'(tbl_idx_q), wb_dat_i,
                                                          wb_sel_i));
      end else if (bus_wr && adr == tpm_pkg::OFS_TBL_DATA && wb_sel_i[0]) begin
         tbl_idx_q <= tbl_idx_q + 9'h001;
      end
   end

   //----------------------------------------------------------------------
   // interrupt status and output
   //----------------------------------------------------------------------
   always_comb begin
      st_set = '0;
      st_set[tpm_pkg::ST_EDGE] = fall & ctrl_q.edge_irq_en;
      st_set[tpm_pkg::ST_CAPT] = period_done;
      st_set[tpm_pkg::ST_GATE] = gate_done;
      st_set[tpm_pkg::ST_RANGE] = (conv_q == tpm_pkg::CV_LOOK) & ~conv_ok;
   end

   // sticky bits, cleared by a read; a new event in that cycle survives
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_q <= '0;
      end else if (bus_rd && adr == tpm_pkg::OFS_STATUS) begin
         status_q <= st_set;
      end else begin
         status_q <= status_q | st_set;
      end
   end

   // level interrupt while any unmasked status bit is set
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(status_q & mask_q);
      end
   end

   a_edge_event: assert property (@(posedge clk_i) disable iff (rst_i)
      fall && ctrl_q.edge_irq_en |=> status_q[tpm_pkg::ST_EDGE])
      else $error("fall did not raise edge event");

   a_gate_fall_irq: assert property (@(posedge clk_i) disable iff (rst_i)
      gate_done |=> status_q[tpm_pkg::ST_GATE] && timer_q == 16'h0000)
      else $error("gate fall missed event or reset");

   a_irq_follows: assert property (@(posedge clk_i) disable iff (rst_i)
      |(status_q & mask_q) |=> irq_o) else $error("interrupt output not raised");

   //----------------------------------------------------------------------
   // read mux and acknowledge
   //----------------------------------------------------------------------
   always_comb begin
      rd_d = '0;
      case (adr)
         tpm_pkg::OFS_CTRL: rd_d = 32'(ctrl_q);
         tpm_pkg::OFS_PULSES: rd_d = 32'(pulses_q);
         tpm_pkg::OFS_PRESET: rd_d = 32'(preset_q);
         tpm_pkg::OFS_MIN: rd_d = 32'(min_q);
         tpm_pkg::OFS_TIMER: rd_d = 32'(timer_q);
         tpm_pkg::OFS_ELAPSED: rd_d = 32'(elapsed_q);
         tpm_pkg::OFS_RESULT: rd_d = 32'(result_q);
         tpm_pkg::OFS_STATUS: rd_d = 32'(status_q);
         tpm_pkg::OFS_MASK: rd_d = 32'(mask_q);
         tpm_pkg::OFS_TBL_IDX: rd_d = 32'(tbl_idx_q);
         tpm_pkg::OFS_TBL_DATA: rd_d = 32'(lut_bus);
         default: rd_d = '0;
      endcase
   end

   // every access answered one cycle after it is seen, unmapped reads zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_rd) begin
            wb_dat_o <= rd_d;
         end
      end
   end

   a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o) else $error("acknowledge held two cycles");

endmodule // tpm_top

/* bench/tpm_xdcr_model.sv */
// behavioural resonant transducer driving a rectangular pulse train
`timescale 1ns/10ps
module tpm_xdcr_model (
   // clock
   input wire logic clk_i,
   // train request and pulse shape in clocks
   input wire logic run_i,
   input wire logic [15:0] hi_clks_i,
   input wire logic [15:0] lo_clks_i,
   // pulse output
   output logic pin_o
);
   // whole periods only, so a train never ends in a short pulse; idle low
   initial begin
      pin_o = 1'b0;
      forever begin
         @(posedge clk_i);
         if (run_i) begin
            pin_o <= 1'b1;
            repeat (hi_clks_i) @(posedge clk_i);
            pin_o <= 1'b0;
            repeat (lo_clks_i - 16'h0001) @(posedge clk_i);
         end
      end
   end
endmodule // tpm_xdcr_model

/* bench/tpm_top_test.sv */
// self-checking bench of the transducer period meter
`timescale 1ns/10ps
module tpm_top_test;
   typedef struct {logic [31:0] e; logic [31:0] m;} tpm_exp_s;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic xdcr_pin_i;
   logic irq_o;
   logic x_run = 1'b0;
   logic [15:0] x_hi = 16'h0018;
   logic [15:0] x_lo = 16'h0018;
   tpm_exp_s exp_q[$];
   int bad_count = 0;
   int num_checks = 0;
   int cyc_count = 0;

   tpm_top i_tpm_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .xdcr_pin_i(xdcr_pin_i), .irq_o(irq_o));
   tpm_xdcr_model i_tpm_xdcr_model (.clk_i(clk_i), .run_i(x_run), .hi_clks_i(x_hi),
      .lo_clks_i(x_lo), .pin_o(xdcr_pin_i));

   //----------------------------------------------------------------------
   // clock, timeout and reporting
   //----------------------------------------------------------------------
   initial begin
      forever #4 clk_i = ~clk_i;
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   // hang guard, well above the longest sequence
   always @(posedge clk_i) begin
      cyc_count++;
      if (cyc_count == 30000) begin
         bad_count++;
         stop_test();
      end
   end

   // read results are compared against the oldest note at the ack edge
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
         chk($sformatf("read at %h", wb_adr_i), wb_dat_o & exp_q[0].m, exp_q[0].e & exp_q[0].m);
         void'(exp_q.pop_front());
      end
   end

   //----------------------------------------------------------------------
   // wishbone classic master
   //----------------------------------------------------------------------
   task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hF;
      wb_dat_i <= dat;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      bus(1'b1, adr, dat);
   endtask

   task automatic rd(input logic [7:0] adr, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back('{e: e, m: m});
      bus(1'b0, adr, 32'h0);
   endtask

   //----------------------------------------------------------------------
   // main sequence
   //----------------------------------------------------------------------
   initial begin
      int n;
      int p;
      int h;
      int el;
      logic [7:0] tbl [4];
      void'($urandom(32'h6D4B7FB2));
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      // reset values, unmapped place, stopped timer holds a written value
      rd(tpm_pkg::OFS_CTRL, 32'h0, 32'hFFFFFFFF);
      rd(tpm_pkg::OFS_PULSES, 32'(tpm_pkg::PULSES_RST), 32'hFF);
      rd(tpm_pkg::OFS_PRESET, 32'(tpm_pkg::PRESET_RST), 32'hFFFF);
      rd(tpm_pkg::OFS_MIN, 32'(tpm_pkg::MIN_RST), 32'hFFFF);
      rd(8'h3C, 32'h0, 32'hFFFFFFFF);
      wr(tpm_pkg::OFS_PULSES, 32'h0);
      rd(tpm_pkg::OFS_PULSES, 32'h1, 32'hFF);
      wr(tpm_pkg::OFS_TIMER, 32'h1234);
      rd(tpm_pkg::OFS_TIMER, 32'h1234, 32'hFFFF);
      // first table entries
      wr(tpm_pkg::OFS_TBL_IDX, 32'h0);
      for (int i = 0; i < 4; i++) begin
         tbl[i] = 8'($urandom);
         wr(tpm_pkg::OFS_TBL_DATA, {24'h0, tbl[i]});
      end
      // period mode, first with the count in range, then below the minimum
      wr(tpm_pkg::OFS_MASK, 32'h2);
      for (int k = 0; k < 2; k++) begin
         n = 2 + $urandom_range(2);
         p = 4 + $urandom_range(4);
         h = 2 + $urandom_range(p - 4);
         el = 9 + n * p;
         wr(tpm_pkg::OFS_PULSES, 32'(n));
         wr(tpm_pkg::OFS_MIN, 32'(k == 1 ? el + 1 : el - 2));
         wr(tpm_pkg::OFS_TIMER, 32'h0);
         wr(tpm_pkg::OFS_CTRL, 32'h5);
         x_hi <= 16'(12 * h);
         x_lo <= 16'(12 * (p - h));
         x_run <= 1'b1;
         // first capture spans the start-up and falls below the minimum; clear it
         repeat (12 * n * p + 12) @(posedge clk_i);
         rd(tpm_pkg::OFS_STATUS, 32'hB, 32'hF);
         repeat (24 * n * p) @(posedge clk_i);
         x_run <= 1'b0;
         repeat (12 * p + 40) @(posedge clk_i);
         rd(tpm_pkg::OFS_ELAPSED, 32'(el), 32'hFFFF);
         rd(tpm_pkg::OFS_RESULT, {24'h0, tbl[2]}, 32'hFF);
         chk("irq", {31'h0, irq_o}, 32'h1);
         rd(tpm_pkg::OFS_STATUS, {28'h0, 1'(k), 3'b011}, 32'hF);
         @(negedge clk_i);
         chk("irq", {31'h0, irq_o}, 32'h0);
         @(posedge clk_i);
         wr(tpm_pkg::OFS_CTRL, 32'h0);
      end
      // gate mode with events masked and edge events off
      wr(tpm_pkg::OFS_MASK, 32'h0);
      wr(tpm_pkg::OFS_TIMER, 32'h0);
      wr(tpm_pkg::OFS_CTRL, 32'h3);
      h = 2 + $urandom_range(6);
      x_hi <= 16'(12 * h);
      x_lo <= 16'(12 * (2 + $urandom_range(3)));
      x_run <= 1'b1;
      repeat (36 * h) @(posedge clk_i);
      x_run <= 1'b0;
      repeat (12 * h + 120) @(posedge clk_i);
      rd(tpm_pkg::OFS_ELAPSED, 32'(h), 32'hFFFF);
      chk("irq", {31'h0, irq_o}, 32'h0);
      rd(tpm_pkg::OFS_STATUS, 32'h4, 32'h7);
      repeat (2) @(posedge clk_i);
      chk("pending", 32'(exp_q.size()), 32'h0);
      stop_test();
   end
endmodule // tpm_top_test
